// [rtl/rot_ctrl_pkg.sv]
// package for the synchronization rotation action control block
// assumes a plain register port with eight-bit data and one clock
package rot_ctrl_pkg;

  // register map
  localparam logic [9:0] ADDR_ROTATION_CONTROL = 10'h03B;
  localparam logic [9:0] ADDR_SYNC_MODE        = 10'h03A;
  localparam logic [9:0] ADDR_OSC_SYNC         = 10'h1E7;

  // rotation_control field positions
  localparam int BIT_SYNC_LOGIC_EN = 7;
  localparam int BIT_RSVD6         = 6;
  localparam int BIT_PERIODIC      = 5;
  localparam int BIT_OSC_RST_TURN  = 4;
  localparam int BIT_ACT_LINK      = 0;
  localparam int BIT_ACT_RAMP      = 1;

  // sync mode field positions
  localparam int BIT_ROT_DONE      = 4;
  localparam int BIT_ONE_SHOT      = 1;
  localparam int BIT_SYNC_RSVD0    = 0;

  // oscillator sync trigger position
  localparam int BIT_OSC_TRIGGER   = 0;

  // writable masks and reset values
  localparam logic [7:0] ROT_WR_MASK   = 8'hF3;
  localparam logic [7:0] ROT_RESET     = 8'hB0;
  localparam logic [7:0] MODE_WR_MASK  = 8'h03;
  localparam logic [7:0] MODE_RESET    = 8'h00;

  // ramp timing: off phase and on phase of the datapath ramp
  localparam int RAMP_OFF_NS      = 800;
  localparam int CLOCK_PERIOD_NS  = 100;
  localparam int RAMP_CYCLES_INT  =
    (RAMP_OFF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [3:0] RAMP_CYCLES = 4'(RAMP_CYCLES_INT);
  localparam logic [3:0] CNT_ZERO    = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;

  // rotation sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAMP_DOWN,
    ST_ROTATE,
    ST_RAMP_UP,
    ST_FINISH
  } rot_state_t;

  // software register port
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // actions driven toward the datapath and links
  typedef struct packed {
    logic link_drop;
    logic link_clk_reset;
    logic ramp_off;
    logic osc_reset;
    logic rotation_strobe;
  } rot_act_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] rot_ctrl;
    logic [7:0] sync_mode;
    logic       rot_done;
    rot_state_t state;
    logic [3:0] cnt;
    logic       want_link;
    logic       want_ramp;
    logic       want_osc;
    rot_act_t   act;
    logic [7:0] rdata;
  } ctrl_state_t;

endpackage

// [rtl/rot_ctrl.sv]
// rotation action control: register, one-shot control and rotation sequence
// assumes sysref edge, digital reset and rotation request are synchronous
// one-cycle pulses coming from the surrounding synchronization logic
//
// Overview of operation
// - with osc-reset-after-turn set, reset all oscillators after reset or turn
// - the separate oscillator sync trigger also resets all oscillators
// - action bit 0 drops links and resets and realigns link clocks
// - action field zero means a rotation touches neither links nor datapath
// - action bit 1 ramps the datapath off and back on around a rotation
// - one-shot mode rotates on the next sysref edge then returns to monitor
// - read-only rotation done flag, resetting to one
module rot_ctrl
  import rot_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // register port
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // synchronization logic events
  input  wire logic       sysref_edge,
  input  wire logic       monitor_rotate,
  input  wire logic       digital_reset_done,
  // actions
  output logic            link_drop,
  output logic            link_clk_reset,
  output logic            ramp_off,
  output logic            osc_reset,
  output logic            rotation_strobe,
  // status
  output logic            sync_logic_enable,
  output logic            periodic_resync_enable
);

  ctrl_state_t q;
  ctrl_state_t d;
  reg_req_t    req;
  logic        start;
  logic        osc_trig;

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    d = q;
    d.act.rotation_strobe = 1'b0;
    d.act.osc_reset = 1'b0;
    // register writes; reserved bits 3:2 stay zero
    if (req.wr && req.addr == ADDR_ROTATION_CONTROL) begin
      d.rot_ctrl = req.wdata & ROT_WR_MASK;
    end
    if (req.wr && req.addr == ADDR_SYNC_MODE) begin
      d.sync_mode = req.wdata & MODE_WR_MASK;
    end
    // trigger register is write-only, self clearing
    osc_trig = req.wr && req.addr == ADDR_OSC_SYNC
               && req.wdata[BIT_OSC_TRIGGER];
    // a one-shot sysref edge or monitor_rotate starts, either one; sync logic must be enabled to rotate
    start = q.rot_ctrl[BIT_SYNC_LOGIC_EN] && q.state == ST_IDLE
            && ((q.sync_mode[BIT_ONE_SHOT] && sysref_edge)
                || monitor_rotate);
    if (start && q.sync_mode[BIT_ONE_SHOT]) begin
      d.sync_mode[BIT_ONE_SHOT] = 1'b0;
    end
    // rotation sequence
    case (q.state)
      ST_IDLE: begin
        if (start) begin
          d.rot_done  = 1'b0;
          d.want_link = q.rot_ctrl[BIT_ACT_LINK];
          d.want_ramp = q.rot_ctrl[BIT_ACT_RAMP];
          d.want_osc  = q.rot_ctrl[BIT_OSC_RST_TURN];
          // field zero goes straight to rotate, no side effects
          if (q.rot_ctrl[BIT_ACT_RAMP]) begin
            d.act.ramp_off = 1'b1;
            d.cnt = RAMP_CYCLES;
            d.state = ST_RAMP_DOWN;
          end else begin
            d.state = ST_ROTATE;
          end
          if (q.rot_ctrl[BIT_ACT_LINK]) begin
            d.act.link_drop = 1'b1;
            d.act.link_clk_reset = 1'b1;
          end
        end
      end
      ST_RAMP_DOWN: begin
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == CNT_ONE) begin
          d.state = ST_ROTATE;
        end
      end
      ST_ROTATE: begin
        // realignment happens here; link clock reset is released
        d.act.rotation_strobe = 1'b1;
        d.act.link_clk_reset = 1'b0;
        d.act.osc_reset = q.want_osc;
        if (q.want_ramp) begin
          d.cnt = RAMP_CYCLES;
          d.state = ST_RAMP_UP;
        end else begin
          d.state = ST_FINISH;
        end
      end
      ST_RAMP_UP: begin
        d.act.ramp_off = 1'b0;
        d.cnt = q.cnt - CNT_ONE;
        if (q.cnt == CNT_ONE || q.cnt == CNT_ZERO) begin
          d.state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        d.act.link_drop = 1'b0;
        d.rot_done = 1'b1;
        d.state = ST_IDLE;
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    // oscillator reset after digital reset or explicit trigger
    if ((digital_reset_done && q.rot_ctrl[BIT_OSC_RST_TURN])
        || osc_trig) begin
      d.act.osc_reset = 1'b1;
    end
    // read data, one cycle later, unmapped reads zero
    d.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ADDR_ROTATION_CONTROL: d.rdata = q.rot_ctrl;
        ADDR_SYNC_MODE: begin
          d.rdata = q.sync_mode;
          d.rdata[BIT_ROT_DONE] = q.rot_done;
        end
        default: d.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.rot_ctrl <= ROT_RESET;
      q.sync_mode <= MODE_RESET;
      q.rot_done <= 1'b1;
      q.state <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign reg_rdata              = q.rdata;
  assign link_drop              = q.act.link_drop;
  assign link_clk_reset         = q.act.link_clk_reset;
  assign ramp_off               = q.act.ramp_off;
  assign osc_reset              = q.act.osc_reset;
  assign rotation_strobe        = q.act.rotation_strobe;
  assign sync_logic_enable      = q.rot_ctrl[BIT_SYNC_LOGIC_EN];
  assign periodic_resync_enable = q.rot_ctrl[BIT_PERIODIC];

endmodule

// [tb/rot_ctrl_sva.sv]
// checker for rot_ctrl, sees only the block's ports
// assumes binding into rot_ctrl; shadows the rotation control register
module rot_ctrl_sva
  import rot_ctrl_pkg::*;
(
  // clock, reset and register port
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // events, actions and status
  input wire logic       sysref_edge,
  input wire logic       monitor_rotate,
  input wire logic       digital_reset_done,
  input wire logic       link_drop,
  input wire logic       link_clk_reset,
  input wire logic       ramp_off,
  input wire logic       osc_reset,
  input wire logic       rotation_strobe,
  input wire logic       sync_logic_enable,
  input wire logic       periodic_resync_enable
);
  logic [7:0] rc_q;
  ////////////////////////////////////////////////////////////////////////////
  // shadow copy; only valid if software never rewrites it mid-rotation
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rc_q <= ROT_RESET;
    else if (reg_wr && reg_addr == ADDR_ROTATION_CONTROL) rc_q <= reg_wdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  osc_trig_a: assert property (reg_wr && reg_addr == ADDR_OSC_SYNC
    && reg_wdata[0] |=> osc_reset) else $error("no trigger reset");
  dig_osc_a: assert property (digital_reset_done && rc_q[4] |=> osc_reset)
    else $error("no reset after digital reset");
  turn_osc_a: assert property (rotation_strobe && rc_q[4] |-> osc_reset)
    else $error("no reset after rotation");
  clk_in_drop_a: assert property (link_clk_reset |-> link_drop)
    else $error("clock reset outside drop");
  clk_end_a: assert property ($fell(link_clk_reset) |-> rotation_strobe)
    else $error("clock reset end off strobe");
  quiet_a: assert property (rc_q[1:0] == 2'h0 |-> !link_drop && !ramp_off)
    else $error("action with field zero");
  ramp_gate_a: assert property (ramp_off |-> rc_q[1])
    else $error("ramp without bit one");
  rd_back_a: assert property (reg_rd && reg_addr == ADDR_ROTATION_CONTROL
    |=> reg_rdata == (rc_q & ROT_WR_MASK)) else $error("bad readback");
  status_a: assert property (sync_logic_enable == rc_q[7]
    && periodic_resync_enable == rc_q[5]) else $error("bad status");
endmodule

// [tb/rot_ctrl_bench.sv]
// bench for rot_ctrl: register rows, then reset and rotation cases
// assumes the package, the block and the checker are compiled first
module rot_ctrl_bench import rot_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, nrst, reg_wr, reg_rd, sysref_edge, monitor_rotate;
  logic       digital_reset_done, link_drop, link_clk_reset, ramp_off;
  logic       osc_reset, rotation_strobe, sync_logic_enable;
  logic       periodic_resync_enable, seen;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         miscompares, compares, n;
  // rows: address, written byte, byte read back
  localparam logic [25:0] ROWS [5] = '{{ADDR_ROTATION_CONTROL, 16'hFFF3},
    {ADDR_ROTATION_CONTROL, 16'h0C00}, {ADDR_SYNC_MODE, 16'hFD11},
    {ADDR_OSC_SYNC, 16'h0100}, {10'h100, 16'hFF00}};
  rot_ctrl DUT (.*);
  ////////////////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each access ends one edge after its strobe drops, so strobes never clash
  task automatic wr(logic [9:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clock);
    reg_wr <= 0;
    @(posedge clock);
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clock);
    reg_rd <= 0;
    @(negedge clock);
    chk(reg_rdata, e);
    @(posedge clock);
  endtask
  // one rotation from sysref (one-shot) or from the monitor input
  task automatic turn(logic [1:0] f, logic sy);
    wr(ADDR_ROTATION_CONTROL, 8'hF0 | {6'h0, f});
    if (sy) wr(ADDR_SYNC_MODE, 8'h02);
    sysref_edge <= sy;
    monitor_rotate <= !sy;
    @(posedge clock);
    // done-flag read rides on the edge after the take, so that a short
    // rotation cannot slip its strobe past the bench while it reads
    sysref_edge <= 0;
    monitor_rotate <= 0;
    reg_addr <= ADDR_SYNC_MODE;
    reg_rd <= 1;
    @(negedge clock);
    chk({6'h0, ramp_off, link_drop}, {6'h0, f});
    @(posedge clock);
    reg_rd <= 0;
    @(negedge clock);
    chk(reg_rdata, 8'h00);
    for (n = 0; n < 40 && rotation_strobe !== 1; n++) @(negedge clock);
    chk({7'h0, rotation_strobe}, 8'h01);
    repeat (16) @(posedge clock);
    rd(ADDR_SYNC_MODE, 8'h10);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {nrst, reg_wr, reg_rd, sysref_edge, monitor_rotate} = '0;
    {digital_reset_done, reg_addr, reg_wdata} = '0;
    for (int p = 0; p < 2; p++) begin
      nrst <= 0;
      repeat (4) @(posedge clock);
      nrst <= 1;
      @(posedge clock);
      if (p == 0) foreach (ROWS[i]) begin
        wr(ROWS[i][25:16], ROWS[i][15:8]);
        rd(ROWS[i][25:16], ROWS[i][7:0]);
      end
    end
    rd(ADDR_ROTATION_CONTROL, ROT_RESET);
    rd(ADDR_SYNC_MODE, 8'h10);
    digital_reset_done <= 1;
    @(posedge clock);
    digital_reset_done <= 0;
    @(negedge clock);
    chk({7'h0, osc_reset}, 8'h01);
    for (int f = 0; f < 4; f++) turn(f[1:0], f == 1);
    seen = 0;
    sysref_edge <= 1;
    @(posedge clock);
    sysref_edge <= 0;
    repeat (12) @(negedge clock) seen |= rotation_strobe;
    chk({7'h0, seen}, 8'h00);
    tally_and_finish;
  end
  // watchdog, far beyond the under two hundred cycles the run needs
  initial begin
    #(2000 * 100);
    miscompares++;
    tally_and_finish;
  end
endmodule
bind rot_ctrl rot_ctrl_sva u_sva (.*);
